// ---- logic/alu_exec_regs.svh ----
// Constants for the accumulator, logic and bit-operation execution block.
// Assumes a 12-bit instruction word and a 32-entry, 8-bit file register.
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH
`define FILE_DEPTH 32
`define ACCUM_RESET 8'h00
`define FILE_RESET 8'h00
`define OP_ADD_ACCUM_FILE 6'h07
`define OP_AND_ACCUM_FILE 6'h05
`define OP_AND_LITERAL 4'hE
`define OP_BIT_CLEAR 4'h4
`define OP_BIT_SET 4'h5
`define OP_BIT_TEST_ZERO 4'h6
`define INSN_NO_OPERATION 12'h000
`define INSN_DEST_BIT 5
`define INSN_MSB 11
`define INSN_OP6_LSB 6
`define INSN_OP4_LSB 8
`define INSN_FILE_MSB 4
`define INSN_BIT_MSB 7
`define INSN_BIT_LSB 5
`define INSN_LIT_MSB 7
`endif

// ---- logic/alu_exec_pkg.sv ----
// Types for the execution block.
// Assumes the constants header is included by the modules that need it.
package alu_exec_pkg;
    typedef enum {
        OpNone,
        OpAddFile,
        OpAndFile,
        OpAndLit,
        OpBitClr,
        OpBitSet,
        OpBitTest
    } op_e;
endpackage

// ---- logic/decode_if.sv ----
// Interface carrying the decoded instruction fields from decoder to core.
// Assumes both ends run on the same instruction clock.
`timescale 1ns/1ns
interface decode_if;
    alu_exec_pkg::op_e op;
    logic [4:0] fileAddr;
    logic [2:0] bitSel;
    logic destFile;
    logic [7:0] literal;
    modport producer (output op, fileAddr, bitSel, destFile, literal);
    modport consumer (input op, fileAddr, bitSel, destFile, literal);
endinterface

// ---- logic/insn_decoder.sv ----
// Combinational decoder of a 12-bit instruction word into fields.
// Assumes the word presented is already the one chosen for execution.
`timescale 1ns/1ns
`include "alu_exec_regs.svh"
module insn_decoder (
    input wire logic [11:0] insn,
    decode_if.producer dec
);
    // Split operand fields; they sit at the same places in every format.
    assign dec.fileAddr = insn[`INSN_FILE_MSB:0];
    assign dec.bitSel = insn[`INSN_BIT_MSB:`INSN_BIT_LSB];
    assign dec.destFile = insn[`INSN_DEST_BIT];
    assign dec.literal = insn[`INSN_LIT_MSB:0];

    // Match opcodes; unknown codes decode to no effect.
    always_comb
    begin
        dec.op = alu_exec_pkg::OpNone;
        if (insn[`INSN_MSB:`INSN_OP6_LSB] == `OP_ADD_ACCUM_FILE)
            dec.op = alu_exec_pkg::OpAddFile;
        else if (insn[`INSN_MSB:`INSN_OP6_LSB] == `OP_AND_ACCUM_FILE)
            dec.op = alu_exec_pkg::OpAndFile;
        else if (insn[`INSN_MSB:`INSN_OP4_LSB] == `OP_AND_LITERAL)
            dec.op = alu_exec_pkg::OpAndLit;
        else if (insn[`INSN_MSB:`INSN_OP4_LSB] == `OP_BIT_CLEAR)
            dec.op = alu_exec_pkg::OpBitClr;
        else if (insn[`INSN_MSB:`INSN_OP4_LSB] == `OP_BIT_SET)
            dec.op = alu_exec_pkg::OpBitSet;
        else if (insn[`INSN_MSB:`INSN_OP4_LSB] == `OP_BIT_TEST_ZERO)
            dec.op = alu_exec_pkg::OpBitTest;
    end
endmodule // insn_decoder

// ---- logic/alu_logic_bit_ops_exec.sv ----
// Executes add, AND and single-bit instructions on the accumulator and
// a 32-entry file register, including the bit-test skip.
// Assumes one instruction word arrives per cycle while insnValid is high,
// and that idle cycles with insnValid low may fall between any two words.
`timescale 1ns/1ns
`include "alu_exec_regs.svh"
module alu_logic_bit_ops_exec (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic insnValid,
    input wire logic [11:0] insnWord,
    output logic [7:0] accum_q,
    output logic carryFlag_q,
    output logic digitCarryFlag_q,
    output logic zeroFlag_q,
    output logic skipActive_q,
    output logic retired_q,
    output logic fileWrEn_q,
    output logic [4:0] fileWrAddr_q,
    output logic [7:0] fileWrData_q
);
    // File register storage. Its contents survive reset, so software
    // must write a location before it relies on its value.
    logic [7:0] fileMem [`FILE_DEPTH];

    // Skip state carried from a bit test to the word that follows it.
    logic skipPending_q;
    logic skipNext;

    // The word actually executed and its addressed operand.
    logic [11:0] execWord;
    logic [7:0] fileVal;
    logic [7:0] bitMask;
    logic testedBitZero;

    // Adder outputs; the extra top bits hold the carries.
    logic [8:0] sum;
    logic [4:0] lowSum;

    // Result and the write-back strobes that steer it.
    logic [7:0] result;
    logic execute;
    logic writeFile;
    logic writeAccum;

    // Which flags the executed operation is allowed to touch.
    logic updatesCarry;
    logic updatesZero;

    // Decoded fields travel from the decoder in one bundle.
    decode_if dec ();

    // A word arriving while a skip is pending is replaced by a no-operation.
    assign execWord = skipPending_q ? `INSN_NO_OPERATION : insnWord;
    assign execute = insnValid;

    // The decoder sees the substituted word, so a skipped word does nothing.
    insn_decoder decoder (
        .insn(execWord),
        .dec(dec)
    );

    assign fileVal = fileMem[dec.fileAddr];
    assign bitMask = 8'h01 << dec.bitSel;
    assign sum = {1'b0, accum_q} + {1'b0, fileVal};
    assign lowSum = {1'b0, accum_q[3:0]} + {1'b0, fileVal[3:0]};

    // Selected bit of the addressed register, as the bit test sees it.
    assign testedBitZero = (fileVal & bitMask) == 8'h00;

    // A clear tested bit arms the skip; a set bit leaves it idle.
    assign skipNext = (dec.op == alu_exec_pkg::OpBitTest)
        && testedBitZero;

    // Only the add moves the carries; add and both ANDs move zero.
    // Bit operations and the test are absent, so they keep every flag.
    assign updatesCarry = (dec.op == alu_exec_pkg::OpAddFile);
    assign updatesZero = (dec.op == alu_exec_pkg::OpAddFile)
        || (dec.op == alu_exec_pkg::OpAndFile)
        || (dec.op == alu_exec_pkg::OpAndLit);

    // Result and destination selection for each operation.
    always_comb
    begin
        result = 8'h00;
        writeFile = 1'b0;
        writeAccum = 1'b0;
        unique case (dec.op)
            alu_exec_pkg::OpAddFile:
            begin
                result = sum[7:0];
                writeFile = dec.destFile;
                writeAccum = !dec.destFile;
            end
            alu_exec_pkg::OpAndFile:
            begin
                result = accum_q & fileVal;
                writeFile = dec.destFile;
                writeAccum = !dec.destFile;
            end
            alu_exec_pkg::OpAndLit:
            begin
                result = accum_q & dec.literal;
                writeAccum = 1'b1;
            end
            alu_exec_pkg::OpBitClr:
            begin
                result = fileVal & ~bitMask;
                writeFile = 1'b1;
            end
            alu_exec_pkg::OpBitSet:
            begin
                result = fileVal | bitMask;
                writeFile = 1'b1;
            end
            // The test only reads the register; nothing is written.
            alu_exec_pkg::OpBitTest:
            begin
                result = fileVal;
            end
            alu_exec_pkg::OpNone:
            begin
                result = 8'h00;
            end
        endcase
    end

    // File register writes. There is no reset network, so the array can
    // map to plain RAM; the price is unknown contents after power-up.
    always_ff @(posedge ref_clk)
    begin
        if (execute && writeFile)
            fileMem[dec.fileAddr] <= result;
    end

    // Accumulator write-back. A replaced word decodes to no operation
    // and so never reaches this register.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            accum_q <= `ACCUM_RESET;
        else if (execute && writeAccum)
            accum_q <= result;
    end

    // Carry and digit carry move only on an executed add; the digit
    // carry is the carry out of bit 3 of the same sum.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            carryFlag_q <= 1'b0;
            digitCarryFlag_q <= 1'b0;
        end
        else if (execute && updatesCarry)
        begin
            carryFlag_q <= sum[8];
            digitCarryFlag_q <= lowSum[4];
        end
    end

    // Zero flag follows the result of the add and of both ANDs; bit
    // operations, the test and a replaced word leave it alone.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            zeroFlag_q <= 1'b0;
        else if (execute && updatesZero)
            zeroFlag_q <= (result == 8'h00);
    end

    // Skip tracking: a clear tested bit kills the next word, a set bit
    // lets it run. The pending skip lasts until one word is consumed;
    // idle cycles leave it armed, so it lands on a real word unless a reset clears it first.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            skipPending_q <= 1'b0;
        else if (execute)
            skipPending_q <= skipNext;
    end

    // Replaced-word marker: high the cycle after a no-operation stood in
    // for a fetched word.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            skipActive_q <= 1'b0;
        else
            skipActive_q <= execute && skipPending_q;
    end

    // Retire marker: every accepted word, a replaced one included, so an
    // observer can see that a taken skip costs two cycles.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            retired_q <= 1'b0;
        else
            retired_q <= execute;
    end

    // Write strobe copy, one pulse per file register write.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            fileWrEn_q <= 1'b0;
        else
            fileWrEn_q <= execute && writeFile;
    end

    // Address and data of the last executed word. They hold while no word
    // is accepted, so a slow observer still sees the last write; the cost
    // is that they also follow words that write nothing.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fileWrAddr_q <= 5'h00;
            fileWrData_q <= `FILE_RESET;
        end
        else if (execute)
        begin
            fileWrAddr_q <= dec.fileAddr;
            fileWrData_q <= result;
        end
    end
endmodule // alu_logic_bit_ops_exec

// ---- sim/alu_logic_bit_ops_exec_props.sv ----
// Checker for the execution block, watching its top-level ports only.
// Assumes one clock domain and the opcode constants of the shared header.
`timescale 1ns/1ns
`include "alu_exec_regs.svh"
module alu_logic_bit_ops_exec_props (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic insnValid,
    input wire logic [11:0] insnWord,
    input wire logic [7:0] accum_q,
    input wire logic carryFlag_q,
    input wire logic digitCarryFlag_q,
    input wire logic zeroFlag_q,
    input wire logic skipActive_q,
    input wire logic retired_q,
    input wire logic fileWrEn_q,
    input wire logic [4:0] fileWrAddr_q,
    input wire logic [7:0] fileWrData_q
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Decoded kinds of the word taken at each edge.
    wire [3:0] hi = insnWord[11:8];
    wire isLit = insnValid && hi == `OP_AND_LITERAL;
    wire isBit = insnValid && (hi == `OP_BIT_SET || hi == `OP_BIT_CLEAR);
    wire isTest = insnValid && hi == `OP_BIT_TEST_ZERO;
    wire isAnd = insnValid && insnWord[11:6] == `OP_AND_ACCUM_FILE;
    wire isAdd = insnValid && insnWord[11:6] == `OP_ADD_ACCUM_FILE;
    wire dst = insnWord[`INSN_DEST_BIT];
    wire [10:0] state = {accum_q, carryFlag_q, digitCarryFlag_q, zeroFlag_q};
    // A replaced word shows skipActive_q, so result checks excuse it.
    AST_AND_LIT:
    assert property (isLit |=> skipActive_q || zeroFlag_q == (accum_q == 8'h00)
        && accum_q == ($past(accum_q) & $past(insnWord[7:0]))) else $error("andlit");
    AST_BIT_OPS:
    assert property (isBit |=> $stable(state)) else $error("bitop state");
    AST_TEST_FLAGS:
    assert property (isTest |=> $stable(state)) else $error("test state");
    AST_AND_CARRY:
    assert property (isAnd |=> $stable({carryFlag_q, digitCarryFlag_q}))
        else $error("and carry");
    AST_ADD_DEST:
    assert property (isAdd && dst |=> $stable(accum_q)) else $error("add dest");
    AST_ADD_ZERO:
    assert property (isAdd && !dst |=> skipActive_q ||
        zeroFlag_q == (accum_q == 8'h00)) else $error("add zero");
    AST_SKIP_HOLD:
    assert property (skipActive_q |-> $stable(state)) else $error("skip hold");
    AST_SKIP_ONCE:
    assert property (skipActive_q |=> !skipActive_q) else $error("skip twice");
    cover property (skipActive_q);
    cover property (fileWrEn_q);
    cover property (carryFlag_q && zeroFlag_q);
endmodule // alu_logic_bit_ops_exec_props
bind alu_logic_bit_ops_exec alu_logic_bit_ops_exec_props u_props (.ref_clk,
    .rst_b, .insnValid, .insnWord, .accum_q, .carryFlag_q, .digitCarryFlag_q,
    .zeroFlag_q, .skipActive_q, .retired_q, .fileWrEn_q, .fileWrAddr_q,
    .fileWrData_q);

// ---- sim/alu_logic_bit_ops_exec_tb_top.sv ----
// Bench for the execution block: words in, accumulator and flags checked.
// Assumes file register 3 is free for scratch use.
`timescale 1ns/1ns
`include "alu_exec_regs.svh"
module alu_logic_bit_ops_exec_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic insnValid = 1'b0;
    logic [11:0] insnWord = 12'h000;
    logic [7:0] accum_q, fileWrData_q;
    logic carryFlag_q, digitCarryFlag_q, zeroFlag_q, skipActive_q;
    logic retired_q, fileWrEn_q;
    logic [4:0] fileWrAddr_q;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    alu_logic_bit_ops_exec u_dut (.ref_clk, .rst_b, .insnValid, .insnWord,
        .accum_q, .carryFlag_q, .digitCarryFlag_q, .zeroFlag_q, .skipActive_q,
        .retired_q, .fileWrEn_q, .fileWrAddr_q, .fileWrData_q);
    // Half period of 5 ns gives the 100 MHz instruction clock.
    always #5 ref_clk = ~ref_clk;
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cmp(input logic [13:0] got, input logic [13:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Valid drops for a cycle after each word, so no input is set twice.
    task run(input logic [11:0] w);
        @(negedge ref_clk);
        insnValid = 1'b1;
        insnWord = w;
        @(negedge ref_clk);
        insnValid = 1'b0;
    endtask
    // Packed as retired, write strobe, carry, digit carry, zero, skip.
    task st(input logic [7:0] a, input logic [5:0] f);
        cmp({accum_q, retired_q, fileWrEn_q, carryFlag_q, digitCarryFlag_q,
            zeroFlag_q, skipActive_q}, {a, f});
    endtask
    // The write copy stands in the cycle after the executing edge.
    task fw(input logic [4:0] a, input logic [7:0] d);
        cmp({fileWrEn_q, fileWrAddr_q, fileWrData_q}, {1'b1, a, d});
    endtask
    // Cuts a hang short; the run needs well under 200 cycles.
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            err_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (20) @(negedge ref_clk);
        st(8'h00, 6'b00_0000);
        rst_b = 1'b1;
        run(12'h163);
        fw(5'd3, 8'h00);
        run({`OP_AND_LITERAL, 8'hFF});
        st(8'h00, 6'b10_0010);
        for (int b = 0; b < 8; b++)
            run({`OP_BIT_SET, b[2:0], 5'd3});
        st(8'h00, 6'b11_0010);
        fw(5'd3, 8'hFF);
        run(12'h1C3);
        st(8'hFF, 6'b10_0000);
        run({`OP_BIT_CLEAR, 3'd7, 5'd3});
        st(8'hFF, 6'b11_0000);
        fw(5'd3, 8'h7F);
        run(12'h143);
        st(8'h7F, 6'b10_0000);
        $display("logic tests done");
        run(12'h1E3);
        st(8'h7F, 6'b11_0100);
        fw(5'd3, 8'hFE);
        run({`OP_AND_LITERAL, 8'h02});
        run(12'h1C3);
        st(8'h00, 6'b10_1110);
        $display("add tests done");
        run({`OP_BIT_TEST_ZERO, 3'd0, 5'd3});
        st(8'h00, 6'b10_1110);
        run(12'h1E3);
        st(8'h00, 6'b10_1111);
        run({`OP_BIT_TEST_ZERO, 3'd1, 5'd3});
        st(8'h00, 6'b10_1110);
        run(12'h1C3);
        st(8'hFE, 6'b10_0000);
        $display("skip tests done");
        // A reset between the test and the next word must cancel the skip.
        run({`OP_BIT_TEST_ZERO, 3'd0, 5'd3});
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        st(8'h00, 6'b00_0000);
        rst_b = 1'b1;
        run(12'h1C3);
        st(8'hFE, 6'b10_0000);
        $display("reset tests done");
        test_done();
    end
endmodule // alu_logic_bit_ops_exec_tb_top
